// file: ftpc_pkg.sv
// Purpose: constants for the fault and thermal protection controller
// Assumes: 20 MHz pclk, APB word addressing (byte address = 4 * index)
// Notes: temperatures in whole degrees C, rolloff level in per mille
`default_nettype none
package ftpc_pkg;
   localparam int unsigned CLK_HZ = 20_000_000;
   // register indices, byte address is four times these
   localparam logic [7:0] IDX_CTRL = 8'h01;
   localparam logic [7:0] IDX_FLAGS = 8'h07;
   localparam logic [7:0] IDX_DELAY = 8'h08;
   localparam logic [7:0] IDX_REPORT = 8'h0A;
   localparam logic [7:0] IDX_IRQ_ST = 8'h0C;
   localparam logic [7:0] IDX_IRQ_CLR = 8'h0D;
   localparam logic [7:0] IDX_IRQ_EN = 8'h0E;
   // field positions
   localparam int CTRL_ROLL_BIT = 0;
   localparam int REP_OS_BIT = 0;
   localparam int REP_TSD_BIT = 1;
   localparam int FLG_OPEN_LSB = 0;
   localparam int FLG_SHORT_LSB = 3;
   localparam int FLG_TSD_BIT = 6;
   localparam int DELAY_W = 4;
   localparam int IRQ_OPEN_BIT = 0;
   localparam int IRQ_SHORT_BIT = 1;
   localparam int IRQ_TSD_BIT = 2;
   // reset values
   localparam logic RST_ROLL_EN = 1'b1;
   localparam logic RST_OS_EN = 1'b1;
   localparam logic RST_TSD_REP = 1'b1;
   localparam logic [DELAY_W-1:0] RST_DELAY = 4'h0;
   // thermal thresholds and rolloff slope
   localparam logic [7:0] T_ROLL_C = 8'h91;
   localparam logic [7:0] T_SHUT_C = 8'hAF;
   localparam logic [7:0] T_RESTART_C = 8'h91;
   localparam logic [15:0] ROLL_SLOPE_PM = 16'h0026;
   localparam logic [15:0] LEVEL_FULL_PM = 16'h03E8;
   localparam logic [15:0] LEVEL_OFF_PM = 16'h0032;
   // timing
   localparam int unsigned SHORT_MS = 5;
   localparam int unsigned SHORT_CYC = SHORT_MS * (CLK_HZ / 1000);
   localparam int unsigned OPEN_STEP_US = 1000;
   localparam int unsigned OPEN_STEP_CYC = OPEN_STEP_US * (CLK_HZ / 1_000_000);
   localparam int CNT_W = 24;
endpackage
`default_nettype wire

// file: ftpc_top.sv
// Purpose: fault flags, thermal rolloff/shutdown and open-drain alert for three LED channels
// Assumes: comparator and temperature inputs synchronous to pclk; APB3 slave with zero-wait answer
// Notes: alert pin is pulled low by raising fault_alert_n_oe; output value is always low
// How it works
// R1: report register disables open/short detection and reporting
// R2: open fault delayed by programmable delay field
// R3: rolloff 3.8 per degree above 145, off at 5
// R4: control bit disables thermal rolloff
// R5: above 175 channels off, flag, alert low
// R6: restart requests ignored until below 145
// R7: restart clears shutdown flag, releases alert
// R8: report bit keeps shutdown off the alert
// R9: open keeps sourcing, flags, alerts, clears on end
// R10: short 5ms cuts to 4mA, flags, restores
// R11: alert low while any reported flag set
`default_nettype none
module ftpc_top import ftpc_pkg::*; #(
   parameter int unsigned SHORT_CYCLES = SHORT_CYC,
   parameter int unsigned OPEN_STEP_CYCLES = OPEN_STEP_CYC
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // detectors and requests
   input wire logic [2:0] open_det,
   input wire logic [2:0] short_det,
   input wire logic [7:0] die_temp_c,
   input wire logic [2:0] chan_on_req,
   // channel controls
   output logic [2:0] chan_enable,
   output logic [2:0] chan_short_limit,
   output logic [9:0] rolloff_permille,
   // alert pin and interrupt
   output logic fault_alert_n_out,
   output logic fault_alert_n_oe,
   output logic irq
);
   localparam logic [CNT_W-1:0] SHORT_LIM = CNT_W'(SHORT_CYCLES);
   localparam logic [CNT_W-1:0] STEP_LIM = CNT_W'(OPEN_STEP_CYCLES);

   typedef struct packed {
      logic roll_en;
      logic [DELAY_W-1:0] delay;
      logic os_en;
      logic tsd_rep;
      logic [2:0] irq_en;
      logic [2:0] irq_st;
      logic [2:0] open_f;
      logic [2:0] short_f;
      logic overtemp_shutdown_flag;
      logic [2:0][CNT_W-1:0] oc_cnt;
      logic [2:0][CNT_W-1:0] sc_cnt;
      logic [2:0] chan_en;
      logic [2:0] limit;
      logic [9:0] level;
      logic alert_oe;
      logic irq;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } ftpc_state_t;

   ftpc_state_t s_q, s_d;

   // saturating persistence counter, cleared when the condition drops
   function automatic logic [CNT_W-1:0] f_persist(input logic [CNT_W-1:0] c, input logic cond,
                                                  input logic [CNT_W-1:0] lim);
      if (!cond) begin
         f_persist = '0;
      end else if (c < lim) begin
         f_persist = c + CNT_W'(1);
      end else begin
         f_persist = c;
      end
   endfunction

   // decode a word index, valid only on aligned addresses
   function automatic logic f_hit(input logic [11:0] a, input logic [7:0] idx);
      f_hit = (a[1:0] == 2'b00) && (a[9:2] == idx) && (a[11:10] == 2'b00);
   endfunction

   logic [CNT_W-1:0] open_lim;
   logic [15:0] roll_drop;
   logic [15:0] level_c;
   logic roll_cut;
   logic wr_acc;
   logic rd_ok;
   logic [31:0] rd_val;
   logic [2:0] open_new;
   logic [2:0] short_new;
   logic [2:0] ev;

   always_comb begin
      s_d = s_q;
      open_lim = CNT_W'(s_q.delay) * STEP_LIM; // R2
      roll_drop = '0;
      level_c = LEVEL_FULL_PM;
      rd_val = '0;
      rd_ok = 1'b1;
      ev = '0;
      open_new = '0;
      short_new = '0;
      // thermal rolloff level, linear above the rollback threshold
      if (s_q.roll_en && die_temp_c > T_ROLL_C) begin
         roll_drop = ROLL_SLOPE_PM * 16'(die_temp_c - T_ROLL_C); // R3
         level_c = (roll_drop >= LEVEL_FULL_PM) ? 16'h0000 : LEVEL_FULL_PM - roll_drop; // R3
      end
      roll_cut = s_q.roll_en && (level_c <= LEVEL_OFF_PM); // R3 R4
      s_d.level = level_c[9:0];
      // open and short persistence per channel
      for (int i = 0; i < 3; i++) begin
         s_d.oc_cnt[i] = f_persist(s_q.oc_cnt[i], open_det[i] && s_q.os_en, open_lim); // R1 R2
         s_d.sc_cnt[i] = f_persist(s_q.sc_cnt[i], short_det[i] && s_q.os_en, SHORT_LIM); // R1 R10
         open_new[i] = open_det[i] && s_q.os_en && (s_q.oc_cnt[i] >= open_lim); // R9
         short_new[i] = short_det[i] && s_q.os_en && (s_q.sc_cnt[i] >= SHORT_LIM); // R10
      end
      s_d.open_f = open_new; // R9
      s_d.short_f = short_new; // R10
      s_d.limit = short_new; // R10
      // thermal shutdown latch; restart needs cool die and a request
      if (die_temp_c > T_SHUT_C) begin
         s_d.overtemp_shutdown_flag = 1'b1; // R5
      end else if (s_q.overtemp_shutdown_flag && die_temp_c < T_RESTART_C && |chan_on_req) begin
         s_d.overtemp_shutdown_flag = 1'b0; // R6 R7
      end
      // open faults keep sourcing; only shutdown and deep rolloff cut the channel
      s_d.chan_en = (s_d.overtemp_shutdown_flag || roll_cut) ? 3'b000 : chan_on_req; // R5 R6 R9
      // alert follows the reported flags
      s_d.alert_oe = (s_q.os_en && |{s_d.open_f, s_d.short_f}) || (s_q.tsd_rep && s_d.overtemp_shutdown_flag); // R8 R11
      // sticky events on rising flags
      ev[IRQ_OPEN_BIT] = |(s_d.open_f & ~s_q.open_f);
      ev[IRQ_SHORT_BIT] = |(s_d.short_f & ~s_q.short_f);
      ev[IRQ_TSD_BIT] = s_d.overtemp_shutdown_flag && !s_q.overtemp_shutdown_flag;
      // apb: answer in the first cycle of the access phase
      s_d.pready = psel && !penable;
      wr_acc = psel && penable && s_q.pready && pwrite;
      unique case (1'b1)
         f_hit(paddr, IDX_CTRL): rd_val[CTRL_ROLL_BIT] = s_q.roll_en;
         f_hit(paddr, IDX_FLAGS): rd_val[FLG_TSD_BIT:0] = {s_q.overtemp_shutdown_flag, s_q.short_f, s_q.open_f};
         f_hit(paddr, IDX_DELAY): rd_val[DELAY_W-1:0] = s_q.delay;
         f_hit(paddr, IDX_REPORT): rd_val[REP_TSD_BIT:REP_OS_BIT] = {s_q.tsd_rep, s_q.os_en};
         f_hit(paddr, IDX_IRQ_ST): rd_val[2:0] = s_q.irq_st;
         f_hit(paddr, IDX_IRQ_CLR): rd_val = '0;
         f_hit(paddr, IDX_IRQ_EN): rd_val[2:0] = s_q.irq_en;
         default: rd_ok = 1'b0;
      endcase
      // answer stands one cycle, so a stale error never leaks into the next access
      s_d.prdata = 32'h0000_0000;
      s_d.pslverr = 1'b0;
      if (psel && !penable) begin
         s_d.prdata = pwrite ? 32'h0000_0000 : rd_val;
         s_d.pslverr = !rd_ok;
      end
      s_d.irq_st = s_q.irq_st;
      if (wr_acc && rd_ok) begin
         if (f_hit(paddr, IDX_CTRL)) s_d.roll_en = pwdata[CTRL_ROLL_BIT]; // R4
         if (f_hit(paddr, IDX_DELAY)) s_d.delay = pwdata[DELAY_W-1:0]; // R2
         if (f_hit(paddr, IDX_REPORT)) begin
            s_d.os_en = pwdata[REP_OS_BIT]; // R1
            s_d.tsd_rep = pwdata[REP_TSD_BIT]; // R8
         end
         if (f_hit(paddr, IDX_IRQ_EN)) s_d.irq_en = pwdata[2:0];
         if (f_hit(paddr, IDX_IRQ_CLR)) s_d.irq_st = s_q.irq_st & ~pwdata[2:0];
      end
      // set wins over a clear in the same cycle
      s_d.irq_st = s_d.irq_st | ev;
      s_d.irq = |(s_d.irq_st & s_d.irq_en);
   end

   // single state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
         s_q.roll_en <= RST_ROLL_EN;
         s_q.delay <= RST_DELAY;
         s_q.os_en <= RST_OS_EN;
         s_q.tsd_rep <= RST_TSD_REP;
         s_q.level <= LEVEL_FULL_PM[9:0];
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from the state flops, except the alert output value, which is tied low
   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign chan_enable = s_q.chan_en;
   assign chan_short_limit = s_q.limit;
   assign rolloff_permille = s_q.level;
   assign fault_alert_n_out = 1'b0; // open drain: only ever pulls low
   assign fault_alert_n_oe = s_q.alert_oe;
   assign irq = s_q.irq;

   // checks
   property p_os_disable;
      @(posedge pclk) disable iff (!presetn)
      !s_q.os_en |=> (s_q.open_f == 3'b000 && s_q.short_f == 3'b000);
   endproperty
   a_os_disable: assert property (p_os_disable) else $error("open/short flag while detection off"); // R1

   property p_open_delay;
      @(posedge pclk) disable iff (!presetn)
      $rose(s_q.open_f[0]) |-> s_q.oc_cnt[0] >= CNT_W'($past(s_q.delay)) * STEP_LIM;
   endproperty
   a_open_delay: assert property (p_open_delay) else $error("open flag before delay"); // R2

   property p_roll_off;
      @(posedge pclk) disable iff (!presetn)
      (s_q.roll_en && s_q.level <= LEVEL_OFF_PM[9:0]) |-> s_q.chan_en == 3'b000;
   endproperty
   a_roll_off: assert property (p_roll_off) else $error("channel on below rolloff floor"); // R3

   property p_roll_dis;
      @(posedge pclk) disable iff (!presetn)
      (!s_q.roll_en ##1 !s_q.roll_en) |-> s_q.level == LEVEL_FULL_PM[9:0];
   endproperty
   a_roll_dis: assert property (p_roll_dis) else $error("rolloff active while disabled"); // R4

   property p_shutdown;
      @(posedge pclk) disable iff (!presetn)
      die_temp_c > T_SHUT_C |=> s_q.overtemp_shutdown_flag && s_q.chan_en == 3'b000;
   endproperty
   a_shutdown: assert property (p_shutdown) else $error("no shutdown above limit"); // R5

   property p_no_restart_hot;
      @(posedge pclk) disable iff (!presetn)
      (s_q.overtemp_shutdown_flag && die_temp_c >= T_RESTART_C) |=> s_q.overtemp_shutdown_flag;
   endproperty
   a_no_restart_hot: assert property (p_no_restart_hot) else $error("restart while still hot"); // R6

   property p_restart;
      @(posedge pclk) disable iff (!presetn)
      $fell(s_q.overtemp_shutdown_flag) |-> !s_q.alert_oe || ($past(s_q.os_en) && |{s_q.open_f, s_q.short_f});
   endproperty
   a_restart: assert property (p_restart) else $error("alert held after restart"); // R7

   property p_tsd_report;
      @(posedge pclk) disable iff (!presetn)
      (s_q.alert_oe && !s_q.tsd_rep && !$past(s_q.tsd_rep)) |-> |{s_q.open_f, s_q.short_f};
   endproperty
   a_tsd_report: assert property (p_tsd_report) else $error("shutdown alert while unreported"); // R8

   property p_open_source;
      @(posedge pclk) disable iff (!presetn)
      (s_q.open_f[0] && !s_q.overtemp_shutdown_flag && s_q.level > LEVEL_OFF_PM[9:0]) |-> s_q.chan_en[0] == $past(chan_on_req[0]);
   endproperty
   a_open_source: assert property (p_open_source) else $error("open fault stopped channel"); // R9

   property p_short_limit;
      @(posedge pclk) disable iff (!presetn)
      s_q.short_f[1] |-> s_q.limit[1] && s_q.alert_oe;
   endproperty
   a_short_limit: assert property (p_short_limit) else $error("short without limit or alert"); // R10

   property p_alert;
      @(posedge pclk) disable iff (!presetn)
      ($past(s_q.tsd_rep) && s_q.overtemp_shutdown_flag) |-> s_q.alert_oe;
   endproperty
   a_alert: assert property (p_alert) else $error("reported flag without alert"); // R11

   // open flag must drop one edge after the condition ends
   property p_open_clear;
      @(posedge pclk) disable iff (!presetn)
      !open_det[0] |=> !s_q.open_f[0];
   endproperty
   a_open_clear: assert property (p_open_clear) else $error("open flag held after recovery"); // R9

   // full current back one edge after the short goes away
   property p_short_restore;
      @(posedge pclk) disable iff (!presetn)
      !short_det[1] |=> !s_q.limit[1];
   endproperty
   a_short_restore: assert property (p_short_restore) else $error("limit held after recovery"); // R10

   // apb answer comes exactly in the first access cycle
   property p_ready_setup;
      @(posedge pclk) disable iff (!presetn)
      (psel && !penable) |=> s_q.pready;
   endproperty
   a_ready_setup: assert property (p_ready_setup) else $error("no ready after setup");

   property p_ready_once;
      @(posedge pclk) disable iff (!presetn)
      (psel && penable) |=> !s_q.pready;
   endproperty
   a_ready_once: assert property (p_ready_once) else $error("ready held past access");

   // unaligned words are refused
   property p_err_unaligned;
      @(posedge pclk) disable iff (!presetn)
      (psel && !penable && paddr[1:0] != 2'h0) |=> s_q.pslverr && s_q.pready;
   endproperty
   a_err_unaligned: assert property (p_err_unaligned) else $error("unaligned access not refused");

   // a shutdown event always lands in the sticky status
   property p_irq_set;
      @(posedge pclk) disable iff (!presetn)
      ev[IRQ_TSD_BIT] |=> s_q.irq_st[IRQ_TSD_BIT];
   endproperty
   a_irq_set: assert property (p_irq_set) else $error("shutdown event lost");

   // level interrupt follows enabled status
   property p_irq_level;
      @(posedge pclk) disable iff (!presetn)
      s_q.irq == |(s_q.irq_st & s_q.irq_en);
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("interrupt out of step with status");
endmodule
`default_nettype wire

// file: ftpc_pkg_unused_guard.sv
`default_nettype none
`default_nettype wire

// file: ftpc_host.sv
// Purpose: host side of the open-drain alert line
// Assumes: the device only ever pulls the line low
// Notes: a released line settles to the pull-up level
`default_nettype none
module ftpc_host (
   // pin from the device
   input wire logic drv_out,
   input wire logic drv_oe,
   // level seen by the host
   output logic alert_level
);
   timeunit 1ns;
   timeprecision 1ns;
   // pull-up wins whenever the device lets go, so a stale low never lingers
   assign alert_level = drv_oe ? drv_out : 1'b1;
endmodule
`default_nettype wire

// file: ftpc_top_test.sv
// Purpose: self-checking bench for the fault and thermal controller
// Assumes: short count 20 and open step 4 to keep the run short
// Notes: alert is judged at the host's pulled-up line
`default_nettype none
module ftpc_top_test import ftpc_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, a_out, a_oe, alert;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [2:0] open_det, short_det, chan_on_req, chan_enable, chan_short_limit;
   logic [7:0] die_temp_c;
   logic [9:0] rolloff_permille;
   int error_cnt = 0;
   int comparisons = 0;
   ftpc_top #(.SHORT_CYCLES(20), .OPEN_STEP_CYCLES(4)) i_ftpc_top (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .open_det(open_det), .short_det(short_det),
      .die_temp_c(die_temp_c), .chan_on_req(chan_on_req), .chan_enable(chan_enable),
      .chan_short_limit(chan_short_limit), .rolloff_permille(rolloff_permille),
      .fault_alert_n_out(a_out), .fault_alert_n_oe(a_oe), .irq(irq));
   ftpc_host i_ftpc_host (.drv_out(a_out), .drv_oe(a_oe), .alert_level(alert));
   // 20 MHz clock
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %0h seen %0h", nm, exp, got);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no local limit: only the watchdog may end a stuck wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, {2'b00, idx, 2'b00}, d, r, e);
   endtask
   task automatic rd(input string nm, input logic [7:0] idx, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, {2'b00, idx, 2'b00}, 32'h0, r, e);
      chk(nm, exp, r);
   endtask
   // reset values and an unmapped word
   task automatic t_reset;
      logic [31:0] r;
      logic e;
      rd("ctrl", IDX_CTRL, 32'h1);
      rd("delay", IDX_DELAY, 32'h0);
      rd("report", IDX_REPORT, 32'h3);
      rd("irq_en", IDX_IRQ_EN, 32'h0);
      apb(1'b0, 12'h040, 32'h0, r, e);
      chk("unmapped err", 32'h1, {31'h0, e});
      chk("unmapped data", 32'h0, r);
      apb(1'b0, 12'h005, 32'h0, r, e);
      chk("unaligned err", 32'h1, {31'h0, e});
      chk("alert idle", 32'h1, {31'h0, alert});
   endtask
   // shutdown, blocked restart, restart, then interrupt clear
   task automatic t_tsd;
      wr(IDX_IRQ_EN, 32'h7);
      chk("on", 32'h7, {29'h0, chan_enable});
      die_temp_c <= 8'hB4;
      wt(3);
      chk("tsd off", 32'h0, {29'h0, chan_enable});
      chk("tsd alert", 32'h0, {31'h0, alert});
      rd("tsd flag", IDX_FLAGS, 32'h40);
      chk("tsd irq", 32'h1, {31'h0, irq});
      die_temp_c <= 8'hA0;
      wt(3);
      rd("blocked", IDX_FLAGS, 32'h40);
      chk("blocked on", 32'h0, {29'h0, chan_enable});
      chk("level 160", 32'h1AE, {22'h0, rolloff_permille});
      die_temp_c <= 8'h8C;
      wt(3);
      rd("restart", IDX_FLAGS, 32'h0);
      chk("restart alert", 32'h1, {31'h0, alert});
      chk("restart on", 32'h7, {29'h0, chan_enable});
      wr(IDX_IRQ_CLR, 32'h7);
      wt(2);
      chk("irq clr", 32'h0, {31'h0, irq});
      rd("irq st", IDX_IRQ_ST, 32'h0);
   endtask
   // rolloff slope, cut-off at 5 percent, and rolloff disabled
   task automatic t_roll;
      die_temp_c <= 8'h96;
      wt(3);
      chk("level 150", 32'h32A, {22'h0, rolloff_permille});
      die_temp_c <= 8'hAA;
      wt(3);
      chk("level 170", 32'h32, {22'h0, rolloff_permille});
      chk("cut off", 32'h0, {29'h0, chan_enable});
      wr(IDX_CTRL, 32'h0);
      wt(3);
      chk("no roll", 32'h3E8, {22'h0, rolloff_permille});
      chk("no roll on", 32'h7, {29'h0, chan_enable});
      wr(IDX_CTRL, 32'h1);
      wr(IDX_REPORT, 32'h1);
      die_temp_c <= 8'hB4;
      wt(3);
      rd("quiet flag", IDX_FLAGS, 32'h40);
      chk("quiet alert", 32'h1, {31'h0, alert});
      die_temp_c <= 8'h19;
      wt(3);
      wr(IDX_REPORT, 32'h3);
   endtask
   // delayed open fault with a masked interrupt, then a short fault
   task automatic t_open_short;
      rd("tsd st", IDX_IRQ_ST, 32'h4);
      wr(IDX_IRQ_EN, 32'h0);
      wr(IDX_IRQ_CLR, 32'h7);
      wr(IDX_DELAY, 32'h2);
      open_det <= 3'h1;
      wt(7);
      chk("open early", 32'h1, {31'h0, alert});
      wt(5);
      chk("open alert", 32'h0, {31'h0, alert});
      chk("open sourcing", 32'h7, {29'h0, chan_enable});
      rd("open flag", IDX_FLAGS, 32'h1);
      rd("open st", IDX_IRQ_ST, 32'h1);
      chk("masked irq", 32'h0, {31'h0, irq});
      open_det <= 3'h0;
      wt(3);
      chk("open gone", 32'h1, {31'h0, alert});
      short_det <= 3'h2;
      wt(18);
      chk("short early", 32'h0, {29'h0, chan_short_limit});
      wt(6);
      chk("short limit", 32'h2, {29'h0, chan_short_limit});
      chk("short alert", 32'h0, {31'h0, alert});
      rd("short flag", IDX_FLAGS, 32'h10);
      short_det <= 3'h0;
      wt(3);
      chk("short gone", 32'h0, {29'h0, chan_short_limit});
      wr(IDX_REPORT, 32'h2);
      open_det <= 3'h1;
      short_det <= 3'h1;
      wt(40);
      rd("masked flags", IDX_FLAGS, 32'h0);
      chk("masked alert", 32'h1, {31'h0, alert});
      chk("masked limit", 32'h0, {29'h0, chan_short_limit});
   endtask
   task automatic test_done;
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      {presetn, psel, penable, pwrite} = 4'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      {open_det, short_det} = 6'h0;
      chan_on_req = 3'h7;
      die_temp_c = 8'h19;
      wt(6);
      presetn <= 1'b1;
      t_reset;
      t_tsd;
      t_roll;
      t_open_short;
      test_done;
   end
   // watchdog well beyond the few hundred cycles the run needs
   initial begin
      wt(20000);
      error_cnt++;
      test_done;
   end
endmodule
`default_nettype wire
